// ===== include/mcs_params.svh
// constants for the main clock mode and edge snapshot block
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

`define MCS_ADR_W        8
`define MCS_IDX_W        6
`define MCS_IDX_LSB      2
`define MCS_IDX_CFG      6'h1b
`define MCS_IDX_SNAP_HI  6'h1d
`define MCS_IDX_SNAP_LO  6'h1e
`define MCS_IDX_SYNC_CTL 6'h30
`define MCS_IDX_STATUS   6'h31

`define MCS_REG_W        16
`define MCS_CFG_RST      16'h3609
`define MCS_SYNC_CTL_RST 16'h0000

`define MCS_FUNC_LSB     0
`define MCS_FUNC_W       3
`define MCS_RATIO_LSB    3
`define MCS_RATIO_W      3
`define MCS_DIVRST_BIT   6
`define MCS_CAL_BIT      9
`define MCS_HIPFD_BIT    11

`define MCS_FUNC_BUF     3'h1
`define MCS_FUNC_DIV     3'h2
`define MCS_FUNC_MULT    3'h3

`define MCS_SMODE_LSB    0
`define MCS_SMODE_W      2
`define MCS_SMODE_DIV    2'h0
`define MCS_SYNCEN_BIT   2
`define MCS_STEP_LSB     4
`define MCS_STEP_W       4

`define MCS_DIV_W        4
`define MCS_SNAP_W       32
`define MCS_SNAP_IDX_W   5
`define MCS_SNAP_LAST    5'h1f

`endif

// ===== include/mcs_pkg.sv
// types shared by the main clock mode and edge snapshot block
`include "mcs_params.svh"

package mcs_pkg;

  typedef enum logic [1:0] {
    MCS_OFF,
    MCS_BUFFER,
    MCS_DIVIDE,
    MCS_MULTIPLY
  } mcs_mode_e;

  typedef enum logic {
    MCS_SNAP_IDLE,
    MCS_SNAP_RUN
  } mcs_snap_e;

  typedef struct packed {
    logic                    src_prev;
    logic [`MCS_DIV_W-1:0]   cnt;
    logic                    out;
  } mcs_div_s;

  typedef struct packed {
    mcs_snap_e                 phase;
    logic [`MCS_SNAP_W-1:0]    raw;
    logic [`MCS_SNAP_IDX_W-1:0] idx;
    logic [`MCS_STEP_W-1:0]    wait_cnt;
    logic [`MCS_SNAP_W-1:0]    snap;
  } mcs_snap_s;

  typedef struct packed {
    logic [`MCS_REG_W-1:0] cfg;
    logic [`MCS_REG_W-1:0] sync_ctl;
    logic                  ack;
    logic [31:0]           rdat;
    logic                  hf_meta;
    logic                  hf_lvl;
    logic                  sr_meta;
    logic                  sr_lvl;
    logic                  sr_prev;
    logic                  cal_start;
    logic                  clk_out;
  } mcs_top_s;

endpackage

// ===== rtl/mcs_main_div.sv
// main clock divider counting edges of the synchronised input clock
`timescale 1ns/100ps
`include "mcs_params.svh"

module mcs_main_div
  import mcs_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_src,
  input  wire logic [`MCS_DIV_W-1:0] i_div_value,
  input  wire logic                  i_restart,
  output logic                       o_div_out
);

  mcs_div_s st_ff;
  mcs_div_s nxt_st;
  logic [`MCS_DIV_W-1:0] half;

  // odd divisors get the longer half high
  assign half = (i_div_value + 4'h1) >> 1;

  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.src_prev = i_src;
    if (i_restart)
    begin
      // held while restart stands, so software sees a clean phase
      nxt_st.cnt = '0;
      nxt_st.out = 1'b0;
    end
    else if (i_src && !st_ff.src_prev)
    begin
      if (st_ff.cnt >= i_div_value - 4'h1)
        nxt_st.cnt = '0;
      else
        nxt_st.cnt = st_ff.cnt + 4'h1;
      nxt_st.out = (nxt_st.cnt < half);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_div_out = st_ff.out;

endmodule

// ===== rtl/mcs_edge_snap.sv
// capture of input clock edge positions after a sync request edge
`timescale 1ns/100ps
`include "mcs_params.svh"

module mcs_edge_snap
  import mcs_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_sample,
  input  wire logic                   i_start,
  input  wire logic [`MCS_STEP_W-1:0] i_step,
  output logic [`MCS_SNAP_W-1:0]      o_snapshot,
  output logic                        o_busy
);

  mcs_snap_s st_ff;
  mcs_snap_s nxt_st;

  // each rising edge marks the two bits around it
  function automatic logic [`MCS_SNAP_W-1:0] mark_edges(
    input logic [`MCS_SNAP_W-1:0] raw
  );
    logic [`MCS_SNAP_W-1:0] m;
    m = '0;
    for (int i = 1; i < `MCS_SNAP_W; i++)
    begin
      if (!raw[i-1] && raw[i])
      begin
        m[i-1] = 1'b1;
        m[i]   = 1'b1;
      end
    end
    m[0]             = 1'b1;
    m[`MCS_SNAP_W-1] = 1'b1;
    return m;
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff.phase)
      MCS_SNAP_IDLE:
      begin
        if (i_start)
        begin
          nxt_st.phase    = MCS_SNAP_RUN;
          nxt_st.raw      = '0;
          nxt_st.idx      = '0;
          nxt_st.wait_cnt = '0;
        end
      end
      MCS_SNAP_RUN:
      begin
        if (st_ff.wait_cnt == '0)
        begin
          nxt_st.raw[st_ff.idx] = i_sample;
          nxt_st.wait_cnt       = i_step;
          if (st_ff.idx == `MCS_SNAP_LAST)
          begin
            // both halves change in one edge
            nxt_st.snap  = mark_edges(nxt_st.raw);
            nxt_st.phase = MCS_SNAP_IDLE;
          end
          else
            nxt_st.idx = st_ff.idx + 5'h1;
        end
        else
          nxt_st.wait_cnt = st_ff.wait_cnt - 4'h1;
      end
      default:
        nxt_st.phase = MCS_SNAP_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_snapshot = st_ff.snap;
  assign o_busy     = (st_ff.phase == MCS_SNAP_RUN);

endmodule

// ===== rtl/mcs_top.sv
// main clock path control and edge snapshot readback, wishbone slave
//
// Functional notes
// - function code picks buffer, divider or multiplier
// - one ratio field serves divide and multiply
// - buffer operation ignores the ratio field
// - divider divides by ratio plus one
// - ratio zero in divider passes clock through
// - multiplier multiplies by the ratio value
// - config write with calibrate bit starts calibration
// - sync request resets divider in mode zero (only while div_sync_en is set)
// - divider reset acts only in divider operation
// - upper word returns snapshot bits 31 to 16
// - one input sample per delay step
// - lowest and highest snapshot bits set in every capture (snapshot is zero after reset)
// - rising edge shows as adjacent set pair
// - lower snapshot half readable at its own word
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`include "mcs_params.svh"

module mcs_top
  import mcs_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_wb_cyc,
  input  wire logic                   i_wb_stb,
  input  wire logic                   i_wb_we,
  input  wire logic [`MCS_ADR_W-1:0]  i_wb_adr,
  input  wire logic [31:0]            i_wb_dat,
  input  wire logic [3:0]             i_wb_sel,
  output logic [31:0]                 o_wb_dat,
  output logic                        o_wb_ack,
  input  wire logic                   i_high_freq_clock_input,
  input  wire logic                   i_sync_request_input,
  output logic                        o_main_clk_out,
  output mcs_mode_e                   o_main_mode,
  output logic [`MCS_DIV_W-1:0]       o_main_div_value,
  output logic [`MCS_RATIO_W-1:0]     o_main_ratio_field_multiply_view,
  output logic                        o_frequency_calibration_trigger,
  output logic                        o_multiplier_high_freq_detector_option
);

  mcs_top_s st_ff;
  mcs_top_s nxt_st;

  logic [`MCS_FUNC_W-1:0]  output_function_selector;
  logic [`MCS_RATIO_W-1:0] ratio;
  logic [`MCS_SMODE_W-1:0] sync_request_mode;
  logic                    div_sync_en;
  logic [`MCS_STEP_W-1:0]  sync_request_delay_step;
  mcs_mode_e               mode;
  logic                    sync_rise;
  logic                    div_restart;
  logic                    div_out;
  logic [`MCS_SNAP_W-1:0]  input_edge_snapshot;
  logic                    snap_busy;
  logic                    bus_req;
  logic                    bus_commit;
  logic [`MCS_IDX_W-1:0]   bus_idx;
  logic                    cfg_write;
  logic                    sync_ctl_write;
  logic                    cal_request;
  logic [`MCS_REG_W-1:0]   status_word;

  // effective operation from the function code and ratio field
  function automatic mcs_mode_e decode_mode(
    input logic [`MCS_FUNC_W-1:0]  func,
    input logic [`MCS_RATIO_W-1:0] r
  );
    mcs_mode_e m;
    m = MCS_OFF;
    case (func)
      `MCS_FUNC_BUF:
      begin
        m = MCS_BUFFER;
      end
      `MCS_FUNC_DIV:
      begin
        if (r == '0)
        begin
          m = MCS_BUFFER;
        end
        else
        begin
          m = MCS_DIVIDE;
        end
      end
      `MCS_FUNC_MULT:
      begin
        // ratio zero is outside the valid range; pass the clock
        if (r == '0)
        begin
          m = MCS_BUFFER;
        end
        else
        begin
          m = MCS_MULTIPLY;
        end
      end
      default:
      begin
        m = MCS_OFF; // reserved code keeps the outputs quiet
      end
    endcase
    return m;
  endfunction

  // merge write data into a 16-bit register by byte lane
  function automatic logic [`MCS_REG_W-1:0] lane_write(
    input logic [`MCS_REG_W-1:0] old,
    input logic [31:0]           dat,
    input logic [3:0]            sel
  );
    logic [`MCS_REG_W-1:0] v;
    v = old;
    if (sel[0])
    begin
      v[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      v[15:8] = dat[15:8];
    end
    return v;
  endfunction

  // readback mux; unmapped words read as zero
  function automatic logic [31:0] read_word(
    input logic [`MCS_IDX_W-1:0]  idx,
    input logic [`MCS_REG_W-1:0]  cfg,
    input logic [`MCS_REG_W-1:0]  sync_ctl,
    input logic [`MCS_SNAP_W-1:0] snap,
    input logic [`MCS_REG_W-1:0]  status
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      `MCS_IDX_CFG:
      begin
        w = {16'h0000, cfg};
      end
      `MCS_IDX_SNAP_HI:
      begin
        w = {16'h0000, snap[`MCS_SNAP_W-1:`MCS_REG_W]};
      end
      `MCS_IDX_SNAP_LO:
      begin
        w = {16'h0000, snap[`MCS_REG_W-1:0]};
      end
      `MCS_IDX_SYNC_CTL:
      begin
        w = {16'h0000, sync_ctl};
      end
      `MCS_IDX_STATUS:
      begin
        w = {16'h0000, status};
      end
      default:
      begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // field views of the two software registers
  assign output_function_selector =
    st_ff.cfg[`MCS_FUNC_LSB +: `MCS_FUNC_W];
  assign ratio = st_ff.cfg[`MCS_RATIO_LSB +: `MCS_RATIO_W];
  assign sync_request_mode =
    st_ff.sync_ctl[`MCS_SMODE_LSB +: `MCS_SMODE_W];
  assign div_sync_en = st_ff.sync_ctl[`MCS_SYNCEN_BIT];
  assign sync_request_delay_step =
    st_ff.sync_ctl[`MCS_STEP_LSB +: `MCS_STEP_W];

  assign mode = decode_mode(output_function_selector, ratio);

  // sync request rising edge, read after the second stage only
  assign sync_rise = st_ff.sr_lvl && !st_ff.sr_prev;

  // software holds the reset bit high then low after a ratio change
  assign div_restart =
    (output_function_selector == `MCS_FUNC_DIV) &&
    (st_ff.cfg[`MCS_DIVRST_BIT] ||
     (sync_rise && div_sync_en &&
      sync_request_mode == `MCS_SMODE_DIV));

  mcs_main_div mcs_main_div_inst
  (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_src       (st_ff.hf_lvl),
    .i_div_value ({1'b0, ratio} + 4'h1),
    .i_restart   (div_restart),
    .o_div_out   (div_out)
  );

  mcs_edge_snap mcs_edge_snap_inst
  (
    .i_ref_clk  (i_ref_clk),
    .i_rstn     (i_rstn),
    .i_sample   (st_ff.hf_lvl),
    .i_start    (sync_rise),
    .i_step     (sync_request_delay_step),
    .o_snapshot (input_edge_snapshot),
    .o_busy     (snap_busy)
  );

  // classic wishbone: answer one cycle after the request is seen,
  // write committed on the edge where the master samples ack
  assign bus_req    = i_wb_cyc && i_wb_stb;
  assign bus_commit = bus_req && st_ff.ack;
  assign bus_idx    = i_wb_adr[`MCS_IDX_LSB +: `MCS_IDX_W];

  assign cfg_write      = bus_commit && i_wb_we &&
                          (bus_idx == `MCS_IDX_CFG);
  assign sync_ctl_write = bus_commit && i_wb_we &&
                          (bus_idx == `MCS_IDX_SYNC_CTL);
  // every write with the bit set retriggers, not just a rise
  assign cal_request    = cfg_write && i_wb_sel[1] &&
                          i_wb_dat[`MCS_CAL_BIT];
  assign status_word    = {11'h000, div_restart, snap_busy,
                           st_ff.clk_out, mode};

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.hf_meta   = i_high_freq_clock_input;
    nxt_st.hf_lvl    = st_ff.hf_meta;
    nxt_st.sr_meta   = i_sync_request_input;
    nxt_st.sr_lvl    = st_ff.sr_meta;
    nxt_st.sr_prev   = st_ff.sr_lvl;
    nxt_st.cal_start = 1'b0;
    nxt_st.ack       = bus_req && !st_ff.ack;

    // data latched when the request is taken, shown with ack
    if (bus_req && !st_ff.ack)
    begin
      nxt_st.rdat = read_word(bus_idx, st_ff.cfg, st_ff.sync_ctl,
                              input_edge_snapshot, status_word);
    end

    // read-only and unmapped words ignore writes but still answer
    if (cfg_write)
    begin
      nxt_st.cfg = lane_write(st_ff.cfg, i_wb_dat, i_wb_sel);
    end
    if (sync_ctl_write)
    begin
      nxt_st.sync_ctl = lane_write(st_ff.sync_ctl, i_wb_dat, i_wb_sel);
    end
    nxt_st.cal_start = cal_request;

    // multiplication happens in the analog path; digital passes input
    case (mode)
      MCS_BUFFER:
      begin
        nxt_st.clk_out = st_ff.hf_lvl;
      end
      MCS_DIVIDE:
      begin
        nxt_st.clk_out = div_out;
      end
      MCS_MULTIPLY:
      begin
        nxt_st.clk_out = st_ff.hf_lvl;
      end
      default:
      begin
        nxt_st.clk_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      st_ff          <= '0;
      st_ff.cfg      <= `MCS_CFG_RST;
      st_ff.sync_ctl <= `MCS_SYNC_CTL_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_wb_dat         = st_ff.rdat;
  assign o_wb_ack         = st_ff.ack;
  assign o_main_clk_out   = st_ff.clk_out;
  assign o_main_mode      = mode;
  assign o_main_div_value = (mode == MCS_DIVIDE) ?
                            ({1'b0, ratio} + 4'h1) : 4'h1;
  assign o_main_ratio_field_multiply_view =
    (mode == MCS_MULTIPLY) ? ratio : 3'h1;
  assign o_frequency_calibration_trigger = st_ff.cal_start;
  // extra current if raised without a register zero write
  assign o_multiplier_high_freq_detector_option =
    st_ff.cfg[`MCS_HIPFD_BIT];

endmodule

// ===== tb/mcs_top_assertions.sv
// concurrent checks on the ports of the main clock path block
`timescale 1ns/100ps
`include "mcs_params.svh"

module mcs_top_assertions
  import mcs_pkg::*;
(
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_wb_cyc,
  input  wire logic                    i_wb_stb,
  input  wire logic                    i_wb_we,
  input  wire logic [`MCS_ADR_W-1:0]   i_wb_adr,
  input  wire logic [31:0]             i_wb_dat,
  input  wire logic [3:0]              i_wb_sel,
  input  wire logic [31:0]             o_wb_dat,
  input  wire logic                    o_wb_ack,
  input  wire mcs_mode_e               o_main_mode,
  input  wire logic [`MCS_DIV_W-1:0]   o_main_div_value,
  input  wire logic [`MCS_RATIO_W-1:0] o_main_ratio_field_multiply_view,
  input  wire logic                    o_frequency_calibration_trigger
);
  logic                    cfg_wr;
  logic                    rd;
  logic [`MCS_RATIO_W-1:0] view;
  logic                    trig;
  logic                    cal_wr;

  // cfg writes take effect at the ack edge, so checks look one cycle later
  assign cfg_wr = o_wb_ack && i_wb_we && i_wb_adr[7:2] == 6'h1b;
  assign rd     = o_wb_ack && !i_wb_we;
  assign view   = o_main_ratio_field_multiply_view;
  assign trig   = o_frequency_calibration_trigger;
  assign cal_wr = cfg_wr && i_wb_sel[1] && i_wb_dat[9];

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack ##1 !o_wb_ack) else $error("ack not a single pulse");
  chk_hi_zero: assert property (
    o_wb_ack |-> o_wb_dat[31:16] == 16'h0) else $error("upper lanes set");
  chk_snap_top: assert property (
    rd && i_wb_adr[7:2] == 6'h1d |-> o_wb_dat[15] || o_wb_dat[15:0] == 0)
    else $error("snapshot top bit clear");
  chk_snap_bottom: assert property (
    rd && i_wb_adr[7:2] == 6'h1e |-> o_wb_dat[0] || o_wb_dat[15:0] == 0)
    else $error("snapshot bottom bit clear");
  chk_buf_mode: assert property (
    cfg_wr && i_wb_sel[0] && i_wb_dat[2:0] == 3'h1 |=> o_main_mode ==
    MCS_BUFFER && o_main_div_value == 4'h1 && view == 3'h1)
    else $error("buffer code not applied");
  chk_div_ratio: assert property (
    cfg_wr && i_wb_sel[0] && i_wb_dat[2:0] == 3'h2 && i_wb_dat[5:3] != 0
    |=> o_main_mode == MCS_DIVIDE &&
    o_main_div_value == {1'b0, $past(i_wb_dat[5:3])} + 4'h1)
    else $error("divide value wrong");
  chk_div_zero: assert property (
    cfg_wr && i_wb_sel[0] && i_wb_dat[5:0] == 6'h02
    |=> o_main_mode == MCS_BUFFER) else $error("ratio zero not buffer");
  chk_mult_ratio: assert property (
    cfg_wr && i_wb_sel[0] && i_wb_dat[2:0] == 3'h3 && i_wb_dat[5:3] != 0
    |=> o_main_mode == MCS_MULTIPLY && view == $past(i_wb_dat[5:3]))
    else $error("multiply value wrong");
  chk_view_idle: assert property (
    o_main_mode != MCS_MULTIPLY |-> view == 3'h1)
    else $error("multiply view outside multiply");
  chk_cal_start: assert property (
    cfg_wr && i_wb_sel[1] && i_wb_dat[9] |=> trig ##1 !trig)
    else $error("calibration not started");
  chk_cal_cause: assert property (
    trig |-> $past(cal_wr))
    else $error("calibration without write");
endmodule

bind mcs_top mcs_top_assertions mcs_top_assertions_inst (
  .i_ref_clk                        (i_ref_clk),
  .i_rstn                           (i_rstn),
  .i_wb_cyc                         (i_wb_cyc),
  .i_wb_stb                         (i_wb_stb),
  .i_wb_we                          (i_wb_we),
  .i_wb_adr                         (i_wb_adr),
  .i_wb_dat                         (i_wb_dat),
  .i_wb_sel                         (i_wb_sel),
  .o_wb_dat                         (o_wb_dat),
  .o_wb_ack                         (o_wb_ack),
  .o_main_mode                      (o_main_mode),
  .o_main_div_value                 (o_main_div_value),
  .o_main_ratio_field_multiply_view (o_main_ratio_field_multiply_view),
  .o_frequency_calibration_trigger  (o_frequency_calibration_trigger)
);

// ===== tb/mcs_top_test.sv
// self-checking bench for the main clock path block
`timescale 1ns/100ps

module mcs_top_test;
  import mcs_pkg::*;

  logic        clk;
  logic        rstn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic [31:0] rdat;
  logic        ack;
  logic        hf;
  logic        sync;
  logic        cko;
  mcs_mode_e   mode;
  logic [3:0]  divv;
  logic [2:0]  view;
  logic        trig;
  logic        hipfd;
  logic [1:0]  hf_cnt;
  logic        hf_run;
  int          n_mismatch;
  int          cmp_count;
  int          n_cal;

  mcs_top mcs_top_inst (
    .i_ref_clk                              (clk),
    .i_rstn                                 (rstn),
    .i_wb_cyc                               (cyc),
    .i_wb_stb                               (stb),
    .i_wb_we                                (we),
    .i_wb_adr                               (adr),
    .i_wb_dat                               (wdat),
    .i_wb_sel                               (sel),
    .o_wb_dat                               (rdat),
    .o_wb_ack                               (ack),
    .i_high_freq_clock_input                (hf),
    .i_sync_request_input                   (sync),
    .o_main_clk_out                         (cko),
    .o_main_mode                            (mode),
    .o_main_div_value                       (divv),
    .o_main_ratio_field_multiply_view       (view),
    .o_frequency_calibration_trigger        (trig),
    .o_multiplier_high_freq_detector_option (hipfd)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // input clock of four cycles; held low when stopped for a known snapshot
  always @(posedge clk)
  begin
    hf_cnt <= hf_run ? hf_cnt + 2'h1 : 2'h0;
    hf <= hf_run & hf_cnt[1];
    if (trig === 1'b1) n_cal <= n_cal + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    sel <= 4'h3;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 16'h0, q);
    chk(q, e);
  endtask

  // fixed fields 15:12 = 3 and 10 = 1 always written as required
  function automatic logic [15:0] cw(input int f, input int r,
                                     input logic rs, input logic c);
    return 16'h3400 | {6'h0, c, 2'h0, rs, r[2:0], f[2:0]};
  endfunction

  function automatic logic [31:0] snap_of(input int ps, input int p);
    logic [31:0] s;
    s = 32'h8000_0001;
    for (int i = 1; i < 32; i++)
      if ((i - 1 + p) % ps < ps / 2 && (i + p) % ps >= ps / 2)
        s = s | (32'h3 << (i - 1));
    return s;
  endfunction

  task automatic per(output int p);
    int n;
    int k;
    int t;
    logic q;
    q = cko;
    k = 0;
    t = 0;
    p = 0;
    for (n = 0; n < 200 && k < 3; n++)
    begin
      @(posedge clk);
      if (cko === 1'b1 && q === 1'b0)
      begin
        k++;
        if (k == 3) p = n - t;
        t = n;
      end
      q = cko;
    end
  endtask

  task automatic t_reset();
    chk({27'h0, mode, 1'b0, trig, hipfd}, 32'h8);
    chk({25'h0, divv, view}, 32'h9);
    rd_chk(8'h6c, 32'h3609);
    wr(8'h74, 16'hffff);
    rd_chk(8'h74, 32'h0);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h78, 32'h0);
    rd_chk(8'hc0, 32'h0);
    rd_chk(8'hc4, 32'h1);
  endtask

  task automatic t_modes();
    mcs_mode_e em;
    for (int f = 0; f < 8; f++)
    begin
      for (int r = 0; r < 8; r++)
      begin
        wr(8'h6c, cw(f, r, 1'b0, 1'b0));
        @(posedge clk);
        em = (f == 1 || ((f == 2 || f == 3) && r == 0)) ? MCS_BUFFER :
             f == 2 ? MCS_DIVIDE : f == 3 ? MCS_MULTIPLY : MCS_OFF;
        chk({30'h0, mode}, {30'h0, em});
        chk({28'h0, divv}, em == MCS_DIVIDE ? r + 1 : 1);
        chk({29'h0, view}, em == MCS_MULTIPLY ? r : 1);
        rd_chk(8'h6c, {16'h0, cw(f, r, 1'b0, 1'b0)});
      end
    end
  endtask

  task automatic t_cal();
    int c0;
    c0 = n_cal;
    wr(8'h6c, cw(3, 2, 1'b0, 1'b1));
    wr(8'h6c, cw(3, 2, 1'b0, 1'b1));
    wr(8'h6c, cw(3, 2, 1'b0, 1'b0) | 16'h0800);
    repeat (3) @(posedge clk);
    chk(n_cal - c0, 2);
    chk({31'h0, hipfd}, 1);
  endtask

  task automatic t_div();
    int p;
    hf_run <= 1'b1;
    wr(8'h6c, cw(2, 7, 1'b0, 1'b0));
    per(p);
    chk(p, 32);
    wr(8'h6c, cw(2, 0, 1'b0, 1'b0));
    per(p);
    chk(p, 4);
    wr(8'h6c, cw(2, 1, 1'b1, 1'b0));
    per(p);
    chk(p, 0);
    wr(8'h6c, cw(2, 1, 1'b0, 1'b0));
    per(p);
    chk(p, 8);
    wr(8'h6c, cw(1, 3, 1'b1, 1'b0));
    per(p);
    chk(p, 4);
  endtask

  task automatic t_snap(input logic [3:0] st, input int ps, input logic run);
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] e;
    hf_run <= run;
    wr(8'hc0, {8'h0, st, 4'h0});
    repeat (8) @(posedge clk);
    sync <= 1'b1;
    repeat (8) @(posedge clk);
    sync <= 1'b0;
    repeat (100) @(posedge clk);
    wb(1'b0, 8'h74, 16'h0, hi);
    wb(1'b0, 8'h78, 16'h0, lo);
    e = snap_of(ps, 0);
    // phase of the input clock against the sync edge is not pinned down
    for (int p = 1; p < ps; p++)
      if ({hi[15:0], lo[15:0]} === snap_of(ps, p)) e = snap_of(ps, p);
    chk({hi[15:0], lo[15:0]}, e);
    chk({hi[31:16], lo[31:16]}, 32'h0);
  endtask

  task automatic t_sync();
    int   c;
    logic q;
    logic hit;
    wr(8'h6c, cw(2, 7, 1'b0, 1'b0));
    wr(8'hc0, 16'h0004);
    for (int k = 0; k < 2; k++)
    begin
      // a restart pulls the next output rise close to the sync edge
      sync <= 1'b1;
      q = cko;
      c = 0;
      hit = 1'b0;
      while (!hit && c < 40)
      begin
        @(posedge clk);
        c++;
        hit = (cko === 1'b1 && q === 1'b0);
        q = cko;
      end
      chk(c > 12 ? c : 0, 0);
      sync <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    wdat = 32'h0;
    sel = 4'h0;
    hf = 1'b0;
    sync = 1'b0;
    hf_cnt = 2'h0;
    hf_run = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    n_cal = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_cal();
    t_div();
    t_sync();
    t_snap(4'h0, 1, 1'b0);
    t_snap(4'h0, 4, 1'b1);
    t_snap(4'h1, 2, 1'b1);
    stop_test();
  end
endmodule
